// file: core/smri_defs.vh
// constants for the supply monitor reset and interrupt block
`ifndef SMRI_DEFS_VH
`define SMRI_DEFS_VH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define SMRI_ADDR_CTRL 8'h00
`define SMRI_ADDR_DELAY 8'h04
`define SMRI_ADDR_OV 8'h08
`define SMRI_ADDR_UV 8'h0c
`define SMRI_ADDR_STG 8'h10
`define SMRI_ADDR_FAULT 8'h14
`define SMRI_ADDR_SYS 8'h18
`define SMRI_ADDR_STAT 8'h1c

// ----------------------------------------------------------------------
// supply bit positions in ov, uv and stg flag words
// ----------------------------------------------------------------------
`define SMRI_B_STBY 0
`define SMRI_B_MCU 1
`define SMRI_B_CORE 2
`define SMRI_B_REF 3
`define SMRI_B_PRE 4
`define SMRI_B_COMM 5
`define SMRI_B_SENA 6
`define SMRI_B_SENB 7
`define SMRI_NSUP 8

// fault word: 0 bias high, 1 bias low, 2 supply ov, 3 bandgap, 4 overload
`define SMRI_F_BHI 0
`define SMRI_F_BLO 1
`define SMRI_F_SOV 2
`define SMRI_F_BG 3
`define SMRI_F_OVL 4
`define SMRI_F_INT 5
// sys word: 0 ot fail, 1 ot warn, 2 safe state, 3 init error
`define SMRI_S_OTF 0
`define SMRI_S_OTW 1
`define SMRI_S_SAFE 2
`define SMRI_S_INIT 3

// ----------------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------------
`define SMRI_DELAY_DEF 11'h3e8
`define SMRI_DELAY_MIN 11'h014
`define SMRI_DELAY_MAX 11'h5dc
`define SMRI_CLK_MHZ 125
`define SMRI_CYCLE_US 10
`define SMRI_FILT_US 8
`define SMRI_FILT_STBY_US 8
`define SMRI_STG_US 3000
`define SMRI_SDT_US 9000

`endif

// file: core/smri_filter.v
// persistence filter: output high once input held high for more than limit cycles
`timescale 1ns/100ps

module smri_filter #(
    parameter WIDTH = 20
) (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // control
    input wire run,
    input wire [WIDTH-1:0] limit,
    // signal
    input wire level_in,
    output reg level_out
);

reg [WIDTH-1:0] count;

always @(posedge aclk) begin
    if (!aresetn || !run || !level_in) begin
        count <= {WIDTH{1'b0}};
        level_out <= 1'b0;
    end else if (count >= limit) begin
        level_out <= 1'b1;
    end else begin
        count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
    end
end

endmodule

// file: core/smri_top.v
// reset and interrupt generator with axi4-lite status and control
//
// Register access over AXI4-Lite and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
`include "smri_defs.vh"

module smri_top #(
    parameter CYCLE_CLKS = `SMRI_CYCLE_US * `SMRI_CLK_MHZ,
    parameter FILT_CLKS = `SMRI_FILT_US * `SMRI_CLK_MHZ,
    parameter FILT_STBY_CLKS = `SMRI_FILT_STBY_US * `SMRI_CLK_MHZ,
    parameter STG_CLKS = `SMRI_STG_US * `SMRI_CLK_MHZ,
    parameter SDT_CLKS = `SMRI_SDT_US * `SMRI_CLK_MHZ
) (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // internal power-on reset, high while held
    input wire por_active,
    // comparator verdicts, one bit per supply
    input wire [7:0] ov_raw,
    input wire [7:0] uv_raw,
    // other device events
    input wire bias_high,
    input wire bias_low,
    input wire internal_supply_fault,
    input wire supply_ov,
    input wire bandgap_mismatch,
    input wire overload,
    input wire overtemp_warning,
    input wire overtemp_shutdown,
    input wire safe_state_trigger,
    input wire soft_reset_req,
    input wire init_timeout,
    // reset pin, open drain
    input wire reset_out_n_in,
    output reg reset_out_n,
    output reg reset_out_oe_n,
    // interrupt and safe state
    output reg int_out_n,
    output reg safe_state_out_a,
    output reg safe_state_out_b,
    // regulator control
    output reg post_reg_off,
    output reg powerdown_req,
    // axi4-lite slave
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready
);

// ----------------------------------------------------------------------
// filters
// ----------------------------------------------------------------------
localparam [7:0] RESET_OV_MASK = 8'h1f;
localparam [7:0] RESET_UV_MASK = 8'h07;
localparam [7:0] INT_OV_MASK = 8'he0;
localparam [7:0] INT_UV_MASK = 8'hf8;
// reference short to ground is flagged and raises the interrupt
localparam [7:0] STG_MASK = 8'hef;
localparam [23:0] FILT_L = FILT_CLKS[23:0];
localparam [23:0] FILT_S = FILT_STBY_CLKS[23:0];
localparam [23:0] STG_L = STG_CLKS[23:0];

wire run = !por_active;
wire [7:0] ov_det;
wire [7:0] uv_det;
wire [7:0] stg_det;

genvar gi;
generate
    for (gi = 0; gi < `SMRI_NSUP; gi = gi + 1) begin : g_sup
        // spikes shorter than the filter never reach a flag
        smri_filter #(.WIDTH(24)) u_ov (
            .aclk(aclk), .aresetn(aresetn), .run(run),
            .limit(gi == `SMRI_B_STBY ? FILT_S : FILT_L),
            .level_in(ov_raw[gi]), .level_out(ov_det[gi])
        );
        smri_filter #(.WIDTH(24)) u_uv (
            .aclk(aclk), .aresetn(aresetn), .run(run),
            .limit(gi == `SMRI_B_STBY ? FILT_S : FILT_L),
            .level_in(uv_raw[gi]), .level_out(uv_det[gi])
        );
        smri_filter #(.WIDTH(24)) u_stg (
            .aclk(aclk), .aresetn(aresetn), .run(run), .limit(STG_L),
            .level_in(uv_raw[gi] & STG_MASK[gi]), .level_out(stg_det[gi])
        );
    end
endgenerate

// ----------------------------------------------------------------------
// sticky flags and control registers
// ----------------------------------------------------------------------
reg [7:0] ov_flags;
reg [7:0] uv_flags;
reg [7:0] stg_flags;
reg [5:0] fault_flags;
reg [3:0] sys_flags;
reg [10:0] delay_cycles;
reg wr_go;
reg [7:0] wr_addr;
reg [31:0] wr_data;
reg [3:0] wr_strb;

wire [5:0] fault_set = {internal_supply_fault, overload, bandgap_mismatch,
    supply_ov, bias_low, bias_high} & {6{run}};
wire [3:0] sys_set = {init_timeout, safe_state_trigger, overtemp_warning,
    overtemp_shutdown} & {4{run}};

// write one to clear; a set in the same cycle wins
function [7:0] sticky8;
    input [7:0] cur;
    input [7:0] set;
    input clr_en;
    input [7:0] clr;
    begin
        sticky8 = (cur & ~(clr_en ? clr : 8'h00)) | set;
    end
endfunction

wire wr_lane0 = wr_go && wr_strb[0];
wire [7:0] next_fault = sticky8({2'b00, fault_flags}, {2'b00, fault_set},
    wr_lane0 && wr_addr == `SMRI_ADDR_FAULT, wr_data[7:0]);
wire [7:0] next_sys = sticky8({4'h0, sys_flags}, {4'h0, sys_set},
    wr_lane0 && wr_addr == `SMRI_ADDR_SYS, wr_data[7:0]);
wire [7:0] next_delay_raw = wr_data[7:0];
wire [10:0] wr_delay = {wr_data[10:8], next_delay_raw};
wire [10:0] next_delay = (wr_delay < `SMRI_DELAY_MIN) ? `SMRI_DELAY_MIN :
    (wr_delay > `SMRI_DELAY_MAX) ? `SMRI_DELAY_MAX : wr_delay;

always @(posedge aclk) begin
    if (!aresetn) begin
        ov_flags <= 8'h00;
        uv_flags <= 8'h00;
        stg_flags <= 8'h00;
        fault_flags <= 6'h00;
        sys_flags <= 4'h0;
        delay_cycles <= `SMRI_DELAY_DEF;
    end else begin
        ov_flags <= sticky8(ov_flags, ov_det,
            wr_lane0 && wr_addr == `SMRI_ADDR_OV, wr_data[7:0]);
        uv_flags <= sticky8(uv_flags, uv_det,
            wr_lane0 && wr_addr == `SMRI_ADDR_UV, wr_data[7:0]);
        stg_flags <= sticky8(stg_flags, stg_det,
            wr_lane0 && wr_addr == `SMRI_ADDR_STG, wr_data[7:0]);
        fault_flags <= next_fault[5:0];
        sys_flags <= next_sys[3:0];
        if (wr_go && wr_addr == `SMRI_ADDR_DELAY && wr_strb[1:0] == 2'b11) begin
            delay_cycles <= next_delay;
        end
    end
end

// ----------------------------------------------------------------------
// reset generator
// ----------------------------------------------------------------------
localparam ST_IDLE = 2'd0;
localparam ST_ASSERT = 2'd1;
localparam ST_HOLD = 2'd2;
localparam ST_SHUT = 2'd3;

reg [1:0] state;
reg [23:0] tick;
reg [10:0] cyc_cnt;
reg second_timeout;

wire cause = run && (|(ov_det & RESET_OV_MASK) || |(uv_det & RESET_UV_MASK)
    || bias_high || bias_low || internal_supply_fault || supply_ov
    || overtemp_shutdown || safe_state_trigger || soft_reset_req);
wire hard_req = run && init_timeout && second_timeout;
wire [23:0] cyc_l = CYCLE_CLKS[23:0];
wire [23:0] sdt_l = SDT_CLKS[23:0];

always @(posedge aclk) begin
    if (!aresetn) begin
        state <= ST_IDLE;
        tick <= 24'h000000;
        cyc_cnt <= 11'h000;
        second_timeout <= 1'b0;
        post_reg_off <= 1'b0;
    end else begin
        if (run && init_timeout) begin
            second_timeout <= 1'b1;
        end
        case (state)
            ST_IDLE: begin
                tick <= 24'h000000;
                cyc_cnt <= 11'h000;
                if (hard_req) begin
                    state <= ST_SHUT;
                    post_reg_off <= 1'b1;
                end else if (cause) begin
                    state <= ST_ASSERT;
                end
            end
            ST_ASSERT: begin
                tick <= 24'h000000;
                cyc_cnt <= 11'h000;
                if (hard_req) begin
                    state <= ST_SHUT;
                    post_reg_off <= 1'b1;
                end else if (!cause) begin
                    state <= ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (hard_req) begin
                    state <= ST_SHUT;
                    post_reg_off <= 1'b1;
                end else if (cause) begin
                    state <= ST_ASSERT;
                end else if (tick >= cyc_l - 24'h000001) begin
                    tick <= 24'h000000;
                    if (cyc_cnt >= delay_cycles - 11'h001) begin
                        state <= ST_IDLE;
                    end else begin
                        cyc_cnt <= cyc_cnt + 11'h001;
                    end
                end else begin
                    tick <= tick + 24'h000001;
                end
            end
            ST_SHUT: begin
                // restart power sequencing after shutdown delay
                if (tick >= sdt_l - 24'h000001) begin
                    tick <= 24'h000000;
                    post_reg_off <= 1'b0;
                    second_timeout <= 1'b0;
                    state <= ST_HOLD;
                end else begin
                    tick <= tick + 24'h000001;
                end
            end
            default: state <= ST_IDLE;
        endcase
    end
end

// ----------------------------------------------------------------------
// pins
// ----------------------------------------------------------------------
wire int_cause = run && (|(ov_det & INT_OV_MASK) || |(uv_det & INT_UV_MASK)
    || |(stg_det & INT_UV_MASK & STG_MASK) || bandgap_mismatch || overload
    || overtemp_warning || overtemp_shutdown);

always @(posedge aclk) begin
    if (!aresetn) begin
        reset_out_n <= 1'b0;
        reset_out_oe_n <= 1'b1;
        int_out_n <= 1'b1;
        safe_state_out_a <= 1'b1;
        safe_state_out_b <= 1'b1;
        powerdown_req <= 1'b0;
    end else begin
        // drive low or release to the pull-up
        reset_out_oe_n <= !(run && (state != ST_IDLE || cause || hard_req));
        reset_out_n <= 1'b0;
        int_out_n <= !int_cause;
        safe_state_out_a <= !(run && safe_state_trigger);
        safe_state_out_b <= !(run && safe_state_trigger);
        powerdown_req <= run && internal_supply_fault;
    end
end

// ----------------------------------------------------------------------
// axi4-lite slave
// ----------------------------------------------------------------------
reg aw_have;
reg w_have;

function mapped;
    input [7:0] a;
    begin
        mapped = (a[1:0] == 2'b00) && (a <= `SMRI_ADDR_STAT);
    end
endfunction

always @(posedge aclk) begin
    if (!aresetn) begin
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= 2'b00;
        aw_have <= 1'b0;
        w_have <= 1'b0;
        wr_go <= 1'b0;
        wr_addr <= 8'h00;
        wr_data <= 32'h00000000;
        wr_strb <= 4'h0;
    end else begin
        wr_go <= 1'b0;
        if (s_axi_awvalid && s_axi_awready) begin
            wr_addr <= s_axi_awaddr;
            aw_have <= 1'b1;
            s_axi_awready <= 1'b0;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            wr_data <= s_axi_wdata;
            wr_strb <= s_axi_wstrb;
            w_have <= 1'b1;
            s_axi_wready <= 1'b0;
        end
        if (aw_have && w_have && !s_axi_bvalid) begin
            wr_go <= mapped(wr_addr);
            s_axi_bresp <= mapped(wr_addr) ? 2'b00 : 2'b10;
            s_axi_bvalid <= 1'b1;
            aw_have <= 1'b0;
            w_have <= 1'b0;
        end
        if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
        end
    end
end

always @(posedge aclk) begin
    if (!aresetn) begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid <= 1'b0;
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= 2'b00;
    end else begin
        if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= mapped(s_axi_araddr) ? 2'b00 : 2'b10;
            case (s_axi_araddr)
                `SMRI_ADDR_CTRL: s_axi_rdata <= {31'h0, second_timeout};
                `SMRI_ADDR_DELAY: s_axi_rdata <= {21'h0, delay_cycles};
                `SMRI_ADDR_OV: s_axi_rdata <= {24'h0, ov_flags};
                `SMRI_ADDR_UV: s_axi_rdata <= {24'h0, uv_flags};
                `SMRI_ADDR_STG: s_axi_rdata <= {24'h0, stg_flags};
                `SMRI_ADDR_FAULT: s_axi_rdata <= {26'h0, fault_flags};
                `SMRI_ADDR_SYS: s_axi_rdata <= {28'h0, sys_flags};
                `SMRI_ADDR_STAT: s_axi_rdata <= {25'h0, reset_out_n_in,
                    post_reg_off, !int_out_n, state, run, cause};
                default: s_axi_rdata <= 32'h00000000;
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end
end

endmodule

// file: test/smri_assertions.sv
// concurrent checks on the reset, interrupt and safe-state outputs
`timescale 1ns/100ps

module smri_checker #(
    parameter CYCLE_CLKS = 1250
) (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // causes
    input wire por_active,
    input wire internal_supply_fault,
    input wire bandgap_mismatch,
    input wire overload,
    input wire overtemp_warning,
    input wire overtemp_shutdown,
    input wire safe_state_trigger,
    input wire soft_reset_req,
    // outputs
    input wire reset_out_n,
    input wire reset_out_oe_n,
    input wire int_out_n,
    input wire safe_state_out_a,
    input wire safe_state_out_b,
    input wire post_reg_off,
    input wire powerdown_req
);
    // ----------------------------------------------------------------
    // length of the current low phase of the reset pin
    // ----------------------------------------------------------------
    reg [15:0] low_cycles;
    wire int_cause;
    assign int_cause = bandgap_mismatch | overload | overtemp_warning |
        overtemp_shutdown;
    always @(posedge aclk) begin
        if (!aresetn || reset_out_oe_n) begin
            low_cycles <= 16'h0000;
        end else if (low_cycles != 16'hffff) begin
            low_cycles <= low_cycles + 16'h0001;
        end
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    drive_low_a: assert property (reset_out_n == 1'b0)
        else $error("reset pin driven high");
    por_idle_a: assert property (por_active [*2] |->
        reset_out_oe_n && int_out_n) else $error("active under por");
    safe_pull_a: assert property (!por_active [*3] ##0
        safe_state_trigger |=> !safe_state_out_a && !safe_state_out_b &&
        !reset_out_oe_n) else $error("safe state not entered");
    soft_keep_a: assert property (!por_active [*3] ##0
        soft_reset_req |=> !reset_out_oe_n && !post_reg_off)
        else $error("soft reset wrong");
    event_int_a: assert property (!por_active [*3] ##0
        int_cause |=> !int_out_n) else $error("event interrupt missing");
    supply_pd_a: assert property (!por_active [*3] ##0
        internal_supply_fault |=> powerdown_req && !reset_out_oe_n)
        else $error("powerdown request missing");
    hard_low_a: assert property (post_reg_off |->
        !reset_out_oe_n) else $error("reset released in shutdown");
    hold_full_a: assert property ($rose(reset_out_oe_n) |->
        low_cycles >= 20 * CYCLE_CLKS) else $error("reset hold too short");
    cover property ($rose(reset_out_oe_n));
    cover property ($fell(int_out_n));
    cover property ($rose(post_reg_off));
endmodule

bind smri_top smri_checker #(.CYCLE_CLKS(CYCLE_CLKS)) smri_checker_inst (
    .aclk(aclk), .aresetn(aresetn), .por_active(por_active),
    .internal_supply_fault(internal_supply_fault),
    .bandgap_mismatch(bandgap_mismatch), .overload(overload),
    .overtemp_warning(overtemp_warning),
    .overtemp_shutdown(overtemp_shutdown),
    .safe_state_trigger(safe_state_trigger),
    .soft_reset_req(soft_reset_req), .reset_out_n(reset_out_n),
    .reset_out_oe_n(reset_out_oe_n), .int_out_n(int_out_n),
    .safe_state_out_a(safe_state_out_a),
    .safe_state_out_b(safe_state_out_b), .post_reg_off(post_reg_off),
    .powerdown_req(powerdown_req));

// file: test/smri_mcu_model.sv
// microcontroller side: resolves the reset wire and sees the interrupt
`timescale 1ns/100ps

module smri_mcu_model (
    // pins from the supply
    input wire reset_out_n,
    input wire reset_out_oe_n,
    input wire int_out_n,
    // levels seen by the microcontroller
    output wire reset_pin,
    output wire irq_seen
);
    // a released wire is lifted by the pull-up current
    assign reset_pin = reset_out_oe_n ? 1'b1 : reset_out_n;
    assign irq_seen = (int_out_n == 1'b0);
endmodule

// file: test/smri_top_bench.sv
// self-checking bench for the reset and interrupt generator
`timescale 1ns/100ps

module smri_top_bench;
    localparam CYC = 4;
    reg aclk, aresetn, por_active;
    reg [7:0] ov_raw, uv_raw, s_axi_awaddr, s_axi_araddr;
    reg [10:0] ev;
    reg [31:0] s_axi_wdata;
    reg s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
    reg s_axi_rready;
    wire reset_out_n, reset_out_oe_n, int_out_n, ssa, ssb, post_reg_off;
    wire powerdown_req, s_axi_awready, s_axi_wready, s_axi_bvalid;
    wire s_axi_arready, s_axi_rvalid, reset_pin;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    integer n_fail, check_count, dly, i, k;

    smri_top #(.CYCLE_CLKS(CYC), .FILT_CLKS(3), .FILT_STBY_CLKS(3),
        .STG_CLKS(20), .SDT_CLKS(30)) smri_top_inst (
        .aclk(aclk), .aresetn(aresetn), .por_active(por_active),
        .ov_raw(ov_raw), .uv_raw(uv_raw), .bias_high(ev[0]),
        .bias_low(ev[1]), .internal_supply_fault(ev[2]),
        .supply_ov(ev[3]), .bandgap_mismatch(ev[4]), .overload(ev[5]),
        .overtemp_warning(ev[6]), .overtemp_shutdown(ev[7]),
        .safe_state_trigger(ev[8]), .soft_reset_req(ev[9]),
        .init_timeout(ev[10]), .reset_out_n_in(reset_pin),
        .reset_out_n(reset_out_n), .reset_out_oe_n(reset_out_oe_n),
        .int_out_n(int_out_n), .safe_state_out_a(ssa),
        .safe_state_out_b(ssb), .post_reg_off(post_reg_off),
        .powerdown_req(powerdown_req), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

    smri_mcu_model smri_mcu_model_inst (.reset_out_n(reset_out_n),
        .reset_out_oe_n(reset_out_oe_n), .int_out_n(int_out_n),
        .reset_pin(reset_pin), .irq_seen());

    // ----------------------------------------------------------------
    // compare, bus and scenario tasks
    // ----------------------------------------------------------------
    task test_done;
        begin
            $display("checks %0d failures %0d", check_count, n_fail);
            if (n_fail == 0 && check_count > 0) begin
                $display("Simulation passed");
            end else begin
                $display("Simulation failed");
            end
            $finish;
        end
    endtask

    task chk(input [8*10-1:0] name, input [31:0] e, input [31:0] g);
        begin
            check_count = check_count + 1;
            if (e !== g) begin
                n_fail = n_fail + 1;
                $display("[FAIL] %0s expected %h seen %h", name, e, g);
            end
        end
    endtask

    task bound(input integer n, input integer lim);
        begin
            if (n >= lim) begin
                n_fail = n_fail + 1;
                $display("[FAIL] wait expected %0d seen %0d", lim - 1, n);
                test_done;
            end
        end
    endtask

    task axw(input [7:0] a, input [31:0] d, input [1:0] er);
        integer n;
        begin
            @(posedge aclk);
            s_axi_awaddr <= a;
            s_axi_wdata <= d;
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            s_axi_bready <= 1'b1;
            n = 0;
            while (n < 50 && !(s_axi_bvalid && s_axi_bready)) begin
                @(posedge aclk);
                if (s_axi_awready) s_axi_awvalid <= 1'b0;
                if (s_axi_wready) s_axi_wvalid <= 1'b0;
                n = n + 1;
            end
            s_axi_bready <= 1'b0;
            bound(n, 50);
            chk("bresp", er, s_axi_bresp);
        end
    endtask

    task axr(input [7:0] a, input [1:0] er, input [31:0] ed);
        integer n;
        begin
            @(posedge aclk);
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
            s_axi_rready <= 1'b1;
            n = 0;
            while (n < 50 && !(s_axi_rvalid && s_axi_rready)) begin
                @(posedge aclk);
                if (s_axi_arready) s_axi_arvalid <= 1'b0;
                n = n + 1;
            end
            s_axi_rready <= 1'b0;
            bound(n, 50);
            chk("rresp", er, s_axi_rresp);
            chk("rdata", ed, s_axi_rdata);
        end
    endtask

    // waits for the pin to rise and checks how long it stayed low
    task hold_chk;
        integer n;
        begin
            n = 0;
            while (n < 400 && reset_pin !== 1'b1) begin
                @(posedge aclk);
                n = n + 1;
            end
            bound(n, 400);
            chk("hold", dly * CYC,
                (n >= dly * CYC && n <= dly * CYC + 8) ? dly * CYC : n);
        end
    endtask

    // holds a cause for len cycles, checks pins, timing and its flag
    task run_case(input [7:0] ov, input [7:0] uv, input [10:0] evc,
        input integer len, input rst_e, input int_e, input [7:0] fa,
        input [31:0] fv);
        integer n;
        begin
            @(posedge aclk);
            ov_raw <= ov;
            uv_raw <= uv;
            ev <= evc;
            repeat (len) @(posedge aclk);
            chk("reset pin", !rst_e, reset_pin);
            chk("int pin", !int_e, int_out_n);
            chk("safe outs", evc[8] ? 2'b00 : 2'b11, {ssa, ssb});
            chk("post off", 1'b0, post_reg_off);
            chk("powerdown", evc[2], powerdown_req);
            ov_raw <= 8'h00;
            uv_raw <= 8'h00;
            ev <= 11'h000;
            if (rst_e) hold_chk;
            repeat (4) @(posedge aclk);
            chk("int idle", 1'b1, int_out_n);
            axr(fa, 2'b00, fv);
            for (n = 8; n < 28; n = n + 4) axw(n[7:0], 32'hff, 2'b00);
        end
    endtask

    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end

    initial begin
        n_fail = 0;
        check_count = 0;
        dly = 25;
        {aresetn, ov_raw, uv_raw, ev} = 0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'b000;
        {s_axi_arvalid, s_axi_rready} = 2'b00;
        por_active = 1'b1;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        run_case(8'h01, 8'h00, 11'h010, 8, 0, 0, 8'h08, 0);
        por_active <= 1'b0;
        axr(8'h04, 2'b00, 32'h3e8);
        axr(8'h40, 2'b10, 32'h0);
        axw(8'h40, 32'h1, 2'b10);
        axw(8'h04, 32'h5, 2'b00);
        axr(8'h04, 2'b00, 32'h14);
        axw(8'h04, 32'h7d0, 2'b00);
        axr(8'h04, 2'b00, 32'h5dc);
        axw(8'h04, 32'h19, 2'b00);
        for (i = 0; i < 8; i = i + 1) begin
            run_case(8'h01 << i, 8'h00, 11'h000, 8, i < 5, i > 4,
                8'h08, 32'h1 << i);
            run_case(8'h00, 8'h01 << i, 11'h000, 8, i < 3, i > 2,
                8'h0c, 32'h1 << i);
        end
        run_case(0, 0, 11'h001, 8, 1, 0, 8'h14, 32'h01);
        run_case(0, 0, 11'h002, 8, 1, 0, 8'h14, 32'h02);
        run_case(0, 0, 11'h004, 8, 1, 0, 8'h14, 32'h20);
        run_case(0, 0, 11'h008, 8, 1, 0, 8'h14, 32'h04);
        run_case(0, 0, 11'h010, 8, 0, 1, 8'h14, 32'h08);
        run_case(0, 0, 11'h020, 8, 0, 1, 8'h14, 32'h10);
        run_case(0, 0, 11'h040, 8, 0, 1, 8'h18, 32'h02);
        run_case(0, 0, 11'h080, 8, 1, 1, 8'h18, 32'h01);
        run_case(0, 0, 11'h100, 8, 1, 0, 8'h18, 32'h04);
        run_case(0, 0, 11'h200, 8, 1, 0, 8'h14, 32'h00);
        run_case(8'h02, 0, 0, 3, 0, 0, 8'h08, 32'h00);
        run_case(8'h20, 0, 0, 3, 0, 0, 8'h08, 32'h00);
        run_case(0, 8'h40, 0, 30, 0, 1, 8'h10, 32'h40);
        run_case(0, 8'h08, 0, 30, 0, 1, 8'h10, 32'h08);
        ev <= 11'h400;
        @(posedge aclk);
        ev <= 11'h000;
        axr(8'h00, 2'b00, 32'h1);
        ev <= 11'h400;
        @(posedge aclk);
        ev <= 11'h000;
        repeat (3) @(posedge aclk);
        chk("post off", 1'b1, post_reg_off);
        chk("reset pin", 1'b0, reset_pin);
        k = 0;
        while (k < 100 && post_reg_off !== 1'b0) begin
            @(posedge aclk);
            k = k + 1;
        end
        chk("shutdown", 24, (k >= 24 && k <= 32) ? 24 : k);
        hold_chk;
        test_done;
    end
endmodule
